//--- common/sio_if.sv
`timescale 1ns/1ps
interface sio_if;
   logic shift;  // one-cycle shift pulse per data bit
   logic load;   // one-cycle parallel load of module inputs
   logic latch;  // one-cycle output latch strobe
   logic sdo;    // data toward the modules
   logic csdo;   // check bit toward the modules
   logic sdi;    // data back from the chain end
   logic csdi;   // check bit back from the chain end

   modport ctrl  (output shift, load, latch, sdo, csdo, input sdi, csdi);
   modport chain (input shift, load, latch, sdo, csdo, output sdi, csdi);
endinterface : sio_if

//--- common/sio_pkg.sv
package sio_pkg;
   // ==========================================================
   // chain geometry
   localparam int NSLOT   = 32;
   localparam int MAX_BITS = 704;
   localparam int IDX_W   = 10;
   localparam int LEN_W   = 12;
   localparam int KIND_W  = 3;
   localparam int CHAN_W  = 3;
   localparam int NS_W    = 6;

   // segment widths in data bits
   localparam logic [LEN_W-1:0] W_SEG4   = 12'h004;
   localparam logic [LEN_W-1:0] W_SEG8   = 12'h008;
   localparam logic [LEN_W-1:0] W_SEG16  = 12'h010;
   localparam logic [LEN_W-1:0] W_SEG32  = 12'h020;
   localparam logic [LEN_W-1:0] W_SEG64  = 12'h040;
   localparam logic [LEN_W-1:0] W_ANA_CH = 12'h010;

   // per-variant limits: total chain and analog share
   localparam logic [LEN_W-1:0] LIM_SMALL  = 12'h100;
   localparam logic [LEN_W-1:0] LIM_MID    = 12'h1E0;
   localparam logic [LEN_W-1:0] LIM_LARGE  = 12'h2C0;
   localparam logic [LEN_W-1:0] ALIM_SMALL = 12'h080;
   localparam logic [LEN_W-1:0] ALIM_MID   = 12'h100;
   localparam logic [LEN_W-1:0] ALIM_LARGE = 12'h200;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int BIT_TIME_NS   = 25000;
   localparam int BIT_CYC       = BIT_TIME_NS / CLK_PERIOD_NS;
   localparam int TICK_W        = 12;

   // ==========================================================
   // request queue
   localparam int FIFO_DEPTH = 8;
   localparam int REQ_W      = 2;

   // ==========================================================
   // types
   typedef enum logic [KIND_W-1:0] {
      SIO_K4, SIO_K8, SIO_K16, SIO_K32, SIO_K64, SIO_KAN8, SIO_KANA
   } sio_kind_t;

   typedef enum logic [REQ_W-1:0] {
      SIO_CYC_NORMAL, SIO_CYC_TIME_IN, SIO_CYC_IRQ_IN, SIO_CYC_INT_OUT
   } sio_cyc_t;

   typedef enum logic [1:0] {
      SIO_VAR_SMALL, SIO_VAR_MID, SIO_VAR_LARGE
   } sio_var_t;

   typedef logic [NSLOT-1:0][KIND_W-1:0] sio_kinds_t;
   typedef logic [NSLOT-1:0][CHAN_W-1:0] sio_chans_t;

   // ==========================================================
   // width decoding, shared by both ends
   function automatic logic [LEN_W-1:0] sio_slot_bits(
      input logic [KIND_W-1:0] kind,
      input logic [CHAN_W-1:0] chans);
      case (sio_kind_t'(kind))
         SIO_K8:   return W_SEG8;
         SIO_K16:  return W_SEG16;
         SIO_K32:  return W_SEG32;
         SIO_K64:  return W_SEG64;
         SIO_KAN8: return W_SEG8;
         SIO_KANA: return LEN_W'(chans) * W_ANA_CH;
         default:  return W_SEG4;
      endcase
   endfunction : sio_slot_bits

   function automatic logic sio_is_analog(input logic [KIND_W-1:0] kind);
      return (kind == SIO_KAN8) || (kind == SIO_KANA);
   endfunction : sio_is_analog

   // check bits are not counted, only data bits
   function automatic logic [LEN_W-1:0] sio_chain_bits(
      input sio_kinds_t kinds, input sio_chans_t chans,
      input logic [NS_W-1:0] nslot, input logic analog_only);
      logic [LEN_W-1:0] sum;
      sum = '0;
      for (int i = 0; i < NSLOT; i++) begin
         if ((i < int'(nslot)) && (!analog_only || sio_is_analog(kinds[i])))
            sum = sum + sio_slot_bits(kinds[i], chans[i]);
      end
      return sum;
   endfunction : sio_chain_bits

   function automatic logic [LEN_W-1:0] sio_max_bits(input logic [1:0] v);
      case (sio_var_t'(v))
         SIO_VAR_SMALL: return LIM_SMALL;
         SIO_VAR_MID:   return LIM_MID;
         default:       return LIM_LARGE;
      endcase
   endfunction : sio_max_bits

   function automatic logic [LEN_W-1:0] sio_max_analog(input logic [1:0] v);
      case (sio_var_t'(v))
         SIO_VAR_SMALL: return ALIM_SMALL;
         SIO_VAR_MID:   return ALIM_MID;
         default:       return ALIM_LARGE;
      endcase
   endfunction : sio_max_analog
endpackage : sio_pkg

//--- logic/sio_chain.sv
`timescale 1ns/1ps
module sio_chain (
   // clock and reset
   input  wire logic                            clk,
   input  wire logic                            rstn,
   // link toward the controller
   sio_if.chain                                 bus,
   // fitted configuration
   input  wire logic [sio_pkg::NS_W-1:0]        cfg_nslot,
   input  wire sio_pkg::sio_kinds_t             cfg_kind,
   input  wire sio_pkg::sio_chans_t             cfg_chan,
   // module terminals
   input  wire logic [sio_pkg::MAX_BITS-1:0]    in_port,
   output logic [sio_pkg::MAX_BITS-1:0]         out_port
);
   // ==========================================================
   // segments of all slots concatenated into one register
   logic [sio_pkg::MAX_BITS-1:0]   data;
   logic [sio_pkg::NSLOT-1:0]      chk;
   logic                           sdi;
   logic                           csdi;

   wire [sio_pkg::LEN_W-1:0] len =
      sio_pkg::sio_chain_bits(cfg_kind, cfg_chan, cfg_nslot, 1'b0);
   wire [sio_pkg::IDX_W-1:0] tap_d = sio_pkg::IDX_W'(len - 1'b1);
   wire [4:0]                tap_c = 5'(cfg_nslot - 1'b1);

   assign bus.sdi  = sdi;
   assign bus.csdi = csdi;

   // shift, load and latch; one check bit per slot
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data     <= '0;
         chk      <= '0;
         sdi      <= 1'b0;
         csdi     <= 1'b0;
         out_port <= '0;
      end else begin
         if (bus.load) data <= in_port;
         else if (bus.shift) data <= {data[sio_pkg::MAX_BITS-2:0], bus.sdo};
         if (bus.shift) chk <= {chk[sio_pkg::NSLOT-2:0], bus.csdo};
         if (bus.latch) out_port <= data;
         sdi  <= data[tap_d];
         csdi <= chk[tap_c];
      end
   end
endmodule : sio_chain

//--- logic/sio_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - each slot: four data bits, one check
// - wide modules bring their own segment
// - normal cycle: inputs in, outputs out
// - interrupt input cycle before interrupt scans
// - timed: all inputs; interrupt: slots 0,1
// - interrupt output only after image written
// - chain length sums data bits only
// - cycle time 25 us per bit
// - 4, 8, 16 bit segment widths
// - 32, 16 per channel, 64 bit modules
// - special analog module uses 8 bits
// - chain limit 256, 480, 704 bits
// - analog limit 128, 256, 512 bits
// - overflow: stop mode, not-ready flag
// - no addresses; whole chain always shifted
module sio_ctrl (
   // clock and reset
   input  wire logic                            clk,
   input  wire logic                            rstn,
   // link toward the module chain
   sio_if.ctrl                                  bus,
   // cycle requests
   input  wire logic                            req_valid,
   input  wire logic [sio_pkg::REQ_W-1:0]       req_kind,
   output logic                                 req_ready,
   // fitted configuration
   input  wire logic [1:0]                      cfg_variant,
   input  wire logic [sio_pkg::NS_W-1:0]        cfg_nslot,
   input  wire sio_pkg::sio_kinds_t             cfg_kind,
   input  wire sio_pkg::sio_chans_t             cfg_chan,
   // image sources from the scan side
   input  wire logic [sio_pkg::MAX_BITS-1:0]    q_image,
   input  wire logic [sio_pkg::MAX_BITS-1:0]    int_q_image,
   input  wire logic                            int_q_write,
   // images and status
   output logic [sio_pkg::MAX_BITS-1:0]         input_image_table,
   output logic [sio_pkg::MAX_BITS-1:0]         int_input_image,
   output logic [sio_pkg::MAX_BITS-1:0]         output_image_table,
   output logic                                 int_out_pending,
   output logic                                 io_not_ready_flag,
   output logic                                 stop_mode,
   output logic                                 bus_error,
   output logic                                 busy,
   output logic                                 done
);
   // ==========================================================
   // state and storage
   typedef enum logic [2:0] {
      ST_IDLE, ST_LOAD, ST_SHIFT, ST_LATCH, ST_DONE
   } sio_state_t;

   localparam int MB = sio_pkg::MAX_BITS;
   localparam logic [sio_pkg::TICK_W-1:0] TICK_LAST =
      sio_pkg::TICK_W'(sio_pkg::BIT_CYC - 1);
   localparam logic [sio_pkg::TICK_W-1:0] TICK_PRE =
      sio_pkg::TICK_W'(sio_pkg::BIT_CYC - 2);

   sio_state_t                      state;
   sio_pkg::sio_cyc_t               cyc;
   logic [MB-1:0]                   shreg;
   logic [MB-1:0]                   rx;
   logic [MB-1:0]                   int_out_image;
   logic [sio_pkg::IDX_W-1:0]       idx;
   logic [sio_pkg::IDX_W-1:0]       up;
   logic [sio_pkg::TICK_W-1:0]      tick;
   logic [sio_pkg::NS_W-1:0]        nslot_q;
   logic [sio_pkg::LEN_W-1:0]       irq_len;
   logic                            chk_bad;
   logic                            shift;
   logic                            load;
   logic                            latch;
   logic                            sdo;
   logic                            csdo;

   // ==========================================================
   // request queue; drained only while idle, so it really fills
   logic                            q_valid;
   logic [sio_pkg::REQ_W-1:0]       q_kind;
   wire                             q_ready = (state == ST_IDLE) & ~stop_mode;

   sio_fifo #(
      .W     (sio_pkg::REQ_W),
      .DEPTH (sio_pkg::FIFO_DEPTH)
   ) u_req_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (req_valid),
      .in_data   (req_kind),
      .in_ready  (req_ready),
      .out_valid (q_valid),
      .out_data  (q_kind),
      .out_ready (q_ready)
   );

   // ==========================================================
   // configuration decode and limit check
   wire [sio_pkg::LEN_W-1:0] total =
      sio_pkg::sio_chain_bits(cfg_kind, cfg_chan, cfg_nslot, 1'b0);
   wire [sio_pkg::LEN_W-1:0] analog =
      sio_pkg::sio_chain_bits(cfg_kind, cfg_chan, cfg_nslot, 1'b1);
   wire [sio_pkg::LEN_W-1:0] slot01 =
      sio_pkg::sio_chain_bits(cfg_kind, cfg_chan, 6'h02, 1'b0);
   wire over = (total > sio_pkg::sio_max_bits(cfg_variant))
             | (analog > sio_pkg::sio_max_analog(cfg_variant))
             | (total == '0) | (cfg_nslot == '0);

   wire start    = q_valid & q_ready;
   wire is_out   = (q_kind == sio_pkg::SIO_CYC_INT_OUT);
   // interrupt output is skipped unless its image has been written
   wire skip     = is_out & ~int_out_pending;
   wire run      = start & ~over & ~skip;
   wire tick_end = (state == ST_SHIFT) & (tick == TICK_LAST);
   wire last_bit = (idx == '0);
   wire chk_on   = (up >= sio_pkg::IDX_W'(nslot_q));
   wire chk_exp  = up[0] ^ nslot_q[0];
   wire drives   = (cyc == sio_pkg::SIO_CYC_NORMAL)
                 | (cyc == sio_pkg::SIO_CYC_INT_OUT);

   // ==========================================================
   // slot 0 and 1 bits merged into the interrupt input image
   wire [MB-1:0] irq_merge;
   genvar g;
   generate
      for (g = 0; g < MB; g++) begin : g_merge
         assign irq_merge[g] = (g < int'(irq_len)) ? rx[g]
                                                   : int_input_image[g];
      end
   endgenerate

   assign bus.shift = shift;
   assign bus.load  = load;
   assign bus.latch = latch;
   assign bus.sdo   = sdo;
   assign bus.csdo  = csdo;

   // ==========================================================
   // sequencer: load, shift every bit, latch, done
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (run) state <= ST_LOAD;
               else if (start & ~over) state <= ST_DONE;
            end
            ST_LOAD:  state <= ST_SHIFT;
            ST_SHIFT: begin
               if (tick_end & last_bit) state <= ST_LATCH;
            end
            ST_LATCH: state <= ST_DONE;
            ST_DONE:  state <= ST_IDLE;
            default:  state <= ST_IDLE;
         endcase
      end
   end

   // stop on overflow; sticky until reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stop_mode         <= 1'b0;
         io_not_ready_flag <= 1'b0;
      end else if (start & over) begin
         stop_mode         <= 1'b1;
         io_not_ready_flag <= 1'b1;
      end
   end

   // cycle setup; whole chain is always shifted, never one module
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cyc     <= sio_pkg::SIO_CYC_NORMAL;
         shreg   <= '0;
         nslot_q <= '0;
         irq_len <= '0;
      end else if (run) begin
         cyc     <= sio_pkg::sio_cyc_t'(q_kind);
         shreg   <= is_out ? int_out_image : q_image;
         nslot_q <= cfg_nslot;
         irq_len <= slot01;
      end
   end

   // bit timing: one period per data bit, pulse near its end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick  <= '0;
         idx   <= '0;
         up    <= '0;
         shift <= 1'b0;
      end else begin
         if (run) begin
            idx <= sio_pkg::IDX_W'(total - 1'b1);
            up  <= '0;
         end else if (tick_end) begin
            idx <= idx - 1'b1;
            up  <= up + 1'b1;
         end
         tick  <= (state != ST_SHIFT || tick_end) ? '0 : tick + 1'b1;
         shift <= (state == ST_SHIFT) & (tick == TICK_PRE);
      end
   end

   // link data and strobes; all from flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sdo   <= 1'b0;
         csdo  <= 1'b0;
         load  <= 1'b0;
         latch <= 1'b0;
      end else begin
         if ((state == ST_SHIFT) & (tick == '0)) begin
            sdo  <= shreg[idx];
            csdo <= up[0];
         end
         load  <= run;
         latch <= tick_end & last_bit & drives;
      end
   end

   // receive side and check bit compare
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx      <= '0;
         chk_bad <= 1'b0;
      end else if (run) begin
         rx      <= '0;
         chk_bad <= 1'b0;
      end else if (tick_end) begin
         rx[idx] <= bus.sdi;
         if (chk_on & (bus.csdi != chk_exp)) chk_bad <= 1'b1;
      end
   end

   // image updates at the end of a cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         input_image_table  <= '0;
         int_input_image    <= '0;
         output_image_table <= '0;
         bus_error          <= 1'b0;
      end else if (state == ST_LATCH) begin
         bus_error <= chk_bad;
         if (cyc == sio_pkg::SIO_CYC_NORMAL) input_image_table <= rx;
         if (cyc == sio_pkg::SIO_CYC_TIME_IN) int_input_image <= rx;
         if (cyc == sio_pkg::SIO_CYC_IRQ_IN)
            int_input_image <= irq_merge;
         if (drives) output_image_table <= shreg;
      end
   end

   // interrupt output image; a write wins over the clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         int_out_image   <= '0;
         int_out_pending <= 1'b0;
      end else begin
         if (int_q_write) int_out_image <= int_q_image;
         if (int_q_write) int_out_pending <= 1'b1;
         else if ((state == ST_LATCH) & (cyc == sio_pkg::SIO_CYC_INT_OUT))
            int_out_pending <= 1'b0;
      end
   end

   // handshake status
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         busy <= (state != ST_IDLE);
         done <= (state == ST_DONE);
      end
   end
endmodule : sio_ctrl

//--- logic/sio_fifo.sv
`timescale 1ns/1ps
module sio_fifo #(
   parameter int W     = 2,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   // ==========================================================
   // storage and pointers; depth must be a power of two
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0]   cnt;

   wire           push     = in_valid & in_ready;
   wire           pop      = out_valid & out_ready;
   wire [AW:0]    next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   assign out_valid = (cnt != '0);
   assign out_data  = mem[rp];

   // pointers; ready is registered so the source sees a clean level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp       <= '0;
         rp       <= '0;
         cnt      <= '0;
         in_ready <= 1'b1;
      end else begin
         if (push) wp <= wp + 1'b1;
         if (pop) rp <= rp + 1'b1;
         cnt      <= next_cnt;
         in_ready <= (next_cnt != (AW+1)'(DEPTH));
      end
   end

   // data store, no reset needed
   always_ff @(posedge clk) begin
      if (push) mem[wp] <= in_data;
   end
endmodule : sio_fifo

//--- test/serial_io_shift_chain_ctrl_tb.sv
`timescale 1ns/1ps
module serial_io_shift_chain_ctrl_tb;
   localparam int MB = sio_pkg::MAX_BITS;
   localparam int LIM [4]  = '{256, 480, 704, 704};
   localparam int ALIM [4] = '{128, 256, 512, 512};
   typedef struct packed {
      logic        stop;
      logic [3:0]  in_img;
      logic [11:0] int_img;
      logic [3:0]  out_img;
      logic [3:0]  port;
   } sio_note_t;
   logic                clk, rstn, req_valid, req_ready, int_q_write;
   logic [1:0]          req_kind, cfg_variant;
   logic [5:0]          cfg_nslot;
   sio_pkg::sio_kinds_t cfg_kind;
   sio_pkg::sio_chans_t cfg_chan;
   logic [MB-1:0]       q_image, int_q_image, in_port, out_port;
   logic [MB-1:0]       input_image_table, int_input_image;
   logic [MB-1:0]       output_image_table;
   logic                int_out_pending, io_not_ready_flag, stop_mode;
   logic                bus_error, busy, done, stop_q;
   int                  fail_count, check_count;
   sio_note_t           m;
   sio_note_t           notes[$];

   // ==========================================================
   // both ends and checker
   sio_if link ();
   sio_ctrl i_sio_ctrl (.clk, .rstn, .bus(link), .req_valid, .req_kind,
      .req_ready, .cfg_variant, .cfg_nslot, .cfg_kind, .cfg_chan,
      .q_image, .int_q_image, .int_q_write, .input_image_table,
      .int_input_image, .output_image_table, .int_out_pending,
      .io_not_ready_flag, .stop_mode, .bus_error, .busy, .done);
   sio_chain i_sio_chain (.clk, .rstn, .bus(link), .cfg_nslot,
      .cfg_kind, .cfg_chan, .in_port, .out_port);
   sio_assertions i_chk (.clk, .rstn, .shift(link.shift),
      .load(link.load), .latch(link.latch), .sdo(link.sdo),
      .csdo(link.csdo));

   // ==========================================================
   // shared tasks
   task automatic chk(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic complete_run();
      if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   function automatic logic [MB-1:0] rnd();
      logic [MB-1:0] r;
      for (int i = 0; i < MB; i += 32) r[i+:32] = $urandom();
      return r;
   endfunction : rnd

   function automatic int wbits(input int k, c);
      case (k)
         1, 5: return 8;
         2: return 16;
         3: return 32;
         4: return 64;
         6: return 16 * c;
         default: return 4;
      endcase
   endfunction : wbits

   task automatic do_reset(input int n);
      @(posedge clk);
      #1 rstn = 1'b0;
      repeat (n) @(posedge clk);
      #1;
      chk("ready in reset", req_ready, 1'b1);
      chk("busy in reset", busy, 1'b0);
      chk("stop in reset", stop_mode, 1'b0);
      rstn = 1'b1;
      m = '0;
   endtask : do_reset

   task automatic send(input logic [1:0] k);
      int w;
      @(posedge clk);
      #1 req_valid = 1'b1;
      req_kind = k;
      w = 0;
      do begin
         @(posedge clk);
         w++;
      end while (req_ready !== 1'b1 && w < 40000);
      #1 req_valid = 1'b0;
   endtask : send

   task automatic wait_idle();
      int w;
      w = 0;
      while ((notes.size() != 0 || busy !== 1'b0) && w < 40000) begin
         @(posedge clk);
         w++;
      end
      #1;
   endtask : wait_idle

   // limits are probed cheaply: request, look, then reset mid-run
   task automatic try_cfg(input int v, ns, sp, sk, bk, ch);
      int tot, an, w, k;
      logic stop;
      tot = 0;
      an = 0;
      do_reset(2);
      for (int i = 0; i < 32; i++) begin
         k = (i < sp) ? sk : bk;
         w = wbits(k, ch);
         if (i < ns) tot += w;
         if (i < ns && (k == 5 || k == 6)) an += w;
         cfg_kind[i] = (i < ns) ? 3'(k) : 3'h4;
      end
      stop = ns == 0 || tot == 0 || tot > LIM[v] || an > ALIM[v];
      cfg_variant = 2'(v);
      cfg_nslot = 6'(ns);
      cfg_chan = {32{3'(ch)}};
      if (stop) notes.push_back(sio_note_t'({1'b1, 24'h000000}));
      send(2'h0);
      repeat (3) @(posedge clk);
      #1;
      if (!stop) chk("stop", stop_mode, 1'b0);
      if (!stop) chk("busy", busy, 1'b1);
   endtask : try_cfg

   // ==========================================================
   // clock, monitors and watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // each result takes the oldest note
   always @(posedge clk) begin
      sio_note_t n;
      if (rstn && (done === 1'b1 || (stop_mode && !stop_q))) begin
         n = notes.pop_front();
         chk("stop", stop_mode, n.stop);
         chk("not ready", io_not_ready_flag, n.stop);
         chk("input image", input_image_table[3:0], n.in_img);
         chk("int input", int_input_image[11:0], n.int_img);
         chk("output image", output_image_table[3:0], n.out_img);
         chk("out port", out_port[3:0], n.port);
         chk("bus error", bus_error, 1'b0);
      end
      stop_q <= stop_mode;
   end

   // generous span over the four long frames
   initial begin
      repeat (95000) @(posedge clk);
      fail_count++;
      complete_run();
   end

   // ==========================================================
   // main sequence
   initial begin
      {rstn, req_valid, req_kind, int_q_write, cfg_variant} = '0;
      {cfg_nslot, cfg_kind, cfg_chan, stop_q} = '0;
      {q_image, int_q_image, in_port} = '0;
      void'($urandom(32'hE850));
      do_reset(12);
      try_cfg(0, 32, 0, 0, 1, 0);
      try_cfg(0, 32, 1, 2, 1, 0);
      try_cfg(0, 9, 9, 6, 0, 1);
      try_cfg(1, 30, 0, 0, 2, 0);
      try_cfg(1, 31, 0, 0, 2, 0);
      try_cfg(1, 32, 32, 5, 0, 0);
      try_cfg(1, 32, 17, 6, 0, 1);
      try_cfg(3, 12, 0, 0, 4, 0);
      try_cfg(2, 22, 0, 0, 3, 0);
      try_cfg(2, 9, 8, 6, 7, 4);
      try_cfg(2, 9, 9, 6, 0, 4);
      try_cfg(0, 0, 0, 0, 0, 0);
      for (int i = 0; i < 6; i++)
         try_cfg($urandom_range(3), $urandom_range(32), $urandom_range(32),
                 $urandom_range(7), $urandom_range(7), $urandom_range(7));
      do_reset(2);
      cfg_variant = 2'h0;
      cfg_kind = '0;
      cfg_chan = '0;
      // timed input, then skipped outputs fill the request queue
      cfg_nslot = 6'h03;
      in_port = rnd();
      m.int_img = in_port[11:0];
      for (int i = 0; i < 10; i++) notes.push_back(m);
      send(2'h1);
      for (int i = 0; i < 8; i++) begin
         send(2'h3);
         chk("queue ready", req_ready, 1'(i < 7));
      end
      chk("queue full", req_ready, 1'b0);
      chk("busy while queued", busy, 1'b1);
      send(2'h3);
      wait_idle();
      chk("queue drained", req_ready, 1'b1);
      // interrupt-driven input touches slots 0 and 1 only
      in_port = rnd();
      m.int_img[7:0] = in_port[7:0];
      notes.push_back(m);
      send(2'h2);
      wait_idle();
      // normal frame; source image changes after the start
      cfg_nslot = 6'h01;
      in_port = rnd();
      q_image = rnd();
      m.in_img = in_port[3:0];
      m.out_img = q_image[3:0];
      m.port = q_image[3:0];
      notes.push_back(m);
      send(2'h0);
      repeat (4) @(posedge clk);
      #1 q_image = ~q_image;
      wait_idle();
      @(posedge clk);
      #1 int_q_image = rnd();
      int_q_write = 1'b1;
      @(posedge clk);
      #1 int_q_write = 1'b0;
      chk("pending", int_out_pending, 1'b1);
      m.out_img = int_q_image[3:0];
      m.port = int_q_image[3:0];
      notes.push_back(m);
      send(2'h3);
      wait_idle();
      chk("pending clear", int_out_pending, 1'b0);
      chk("notes left", notes.size(), 0);
      complete_run();
   end
endmodule : serial_io_shift_chain_ctrl_tb

//--- test/sio_assertions.sv
`timescale 1ns/1ps
module sio_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // link signals
   input wire logic shift,
   input wire logic load,
   input wire logic latch,
   input wire logic sdo,
   input wire logic csdo
);
   localparam int BIT_GAP = sio_pkg::BIT_CYC - 1;
   logic [11:0] gap;
   logic [9:0]  idx;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // ==========================================================
   // helper counters
   // cycles since last load or shift, bits sent since load
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gap <= '0;
         idx <= '0;
      end else begin
         gap <= (load || shift) ? 12'h000 : gap + 12'h001;
         idx <= load ? 10'h000 : idx + 10'(shift);
      end
   end

   // ==========================================================
   // properties
   sequence s_quiet;
      (!shift && !latch && !load) [*8];
   endsequence
   sequence s_settle;
      (!shift && !load) [*2];
   endsequence

   property p_one_strobe;
      $onehot0({shift, load, latch});
   endproperty
   property p_bit_spacing;
      shift |-> gap == 12'(BIT_GAP);
   endproperty
   property p_latch_final;
      latch |-> $past(shift);
   endproperty
   property p_check_parity;
      shift |-> csdo == idx[0];
   endproperty
   property p_hold_data;
      shift |-> $stable(sdo) && $stable(csdo);
   endproperty
   property p_quiet_after_load;
      load |=> s_quiet;
   endproperty
   property p_latch_end;
      latch |=> s_settle;
   endproperty
   property p_latch_nonempty;
      latch |-> idx != 10'h000;
   endproperty

   a_one_strobe: assert property (p_one_strobe)
      else $error("link strobes overlap");
   a_bit_spacing: assert property (p_bit_spacing)
      else $error("shift pulse off its bit period");
   a_latch_final: assert property (p_latch_final)
      else $error("latch not right after last shift");
   a_check_parity: assert property (p_check_parity)
      else $error("check bit has wrong parity");
   a_hold_data: assert property (p_hold_data)
      else $error("data moved in shift cycle");
   a_quiet_after_load: assert property (p_quiet_after_load)
      else $error("strobe too soon after load");
   a_latch_end: assert property (p_latch_end)
      else $error("activity right after latch");
   a_latch_nonempty: assert property (p_latch_nonempty)
      else $error("latch without any shifted bit");
   c_latch: cover property (latch);
endmodule : sio_assertions
